/* hw/mttu_pkg.sv */
package mttu_pkg;

    // Bus geometry
    localparam int          ADDR_W      = 8;

    // Register byte addresses, one aligned word each
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_CNT_LO  = 8'h04;
    localparam logic [7:0]  OFF_CNT_HI  = 8'h08;
    localparam logic [7:0]  OFF_PER_LO  = 8'h0c;
    localparam logic [7:0]  OFF_PER_HI  = 8'h10;
    localparam logic [7:0]  OFF_CAPTURE_ONE_INPUT    = 8'h14;
    localparam logic [7:0]  OFF_FLT     = 8'h18;
    localparam logic [7:0]  OFF_IRQ_FLG = 8'h1c;
    localparam logic [7:0]  OFF_IRQ_EN  = 8'h20;
    localparam logic [7:0]  OFF_IRQ_PRI = 8'h24;

    // Reset values and implemented-bit masks
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [7:0]  CAPTURE_ONE_INPUT_MASK   = 8'h4f;
    localparam logic [7:0]  FLT_MASK    = 8'h7f;
    localparam int          FILT_EN_BIT = 6;
    localparam int          IRQ_BIT     = 0;

    // Capture channel one modes that arm the trigger reset
    localparam logic [3:0]  CAPM_TRIG_A = 4'he;
    localparam logic [3:0]  CAPM_TRIG_B = 4'hf;

    // Noise filter stable sample count
    localparam int          FILT_STABLE = 3;

    // Prescale select codes and terminal prescaler counts
    localparam logic [1:0]  PS_DIV1     = 2'h0;
    localparam logic [1:0]  PS_DIV2     = 2'h1;
    localparam logic [1:0]  PS_DIV4     = 2'h2;
    localparam logic [1:0]  PS_DIV8     = 2'h3;
    localparam logic [2:0]  PS_LAST1    = 3'h0;
    localparam logic [2:0]  PS_LAST2    = 3'h1;
    localparam logic [2:0]  PS_LAST4    = 3'h3;
    localparam logic [2:0]  PS_LAST8    = 3'h7;

    // Timing: clock period and instruction cycle in ns
    localparam int          CLK_NS      = 25;
    localparam int          TCY_NS      = 100;

    // Instruction cycle phases, Gray coded
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } mttu_phase_e;

    // Timer control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       sleep_run_enable;
        logic       trigger_reset_disable;
        logic       single_shot_select;
        logic [1:0] prescale_select;
        logic       no_sync_select;
        logic       external_clock_select;
        logic       timer_run_bit;
    } mttu_ctrl_s;

    // Terminal prescaler count for a select code
    function automatic logic [2:0] mttu_presc_last(input logic [1:0] sel);
        logic [2:0] r;
        r = PS_LAST1;
        case (sel)
            PS_DIV2: r = PS_LAST2;
            PS_DIV4: r = PS_LAST4;
            PS_DIV8: r = PS_LAST8;
            default: r = PS_LAST1;
        endcase
        return r;
    endfunction

endpackage

/* hw/mttu_filter.sv */
`timescale 1ns/1ps
module mttu_filter
    import mttu_pkg::*;
#(
    parameter int DEPTH = FILT_STABLE
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    // Sampling strobe and enable
    input  wire logic i_sample,
    input  wire logic i_en,
    // Raw and filtered level
    input  wire logic i_in,
    output logic      o_out
);

    // Depth below two would make the filter a plain sampler
    if (DEPTH < 2) begin : g_chk
        $error("mttu_filter DEPTH must be at least 2");
    end

    logic [DEPTH-1:0] hist_q;
    logic [DEPTH-1:0] hist_d;
    logic             out_q;

    // Newest sample enters at bit 0
    assign hist_d = {hist_q[DEPTH-2:0], i_in};
    assign o_out  = out_q;

    // When enabled, the level moves only when all held samples agree
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hist_q <= '0;
            out_q  <= 1'b0;
        end else if (i_sample) begin
            hist_q <= hist_d;
            if (!i_en) begin
                out_q <= i_in;
            end else if (&hist_d) begin
                out_q <= 1'b1;
            end else if (~|hist_d) begin
                out_q <= 1'b0;
            end
        end
    end

endmodule

/* hw/mttu_top.sv */
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module mttu_top
    import mttu_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Device state
    input  wire logic              i_sleep,
    input  wire logic              i_bor,
    // External count input and capture channel one event
    input  wire logic              i_ext_count,
    input  wire logic              i_capture_one_input_event,
    // Results
    output logic                   o_trigger,
    output logic                   o_irq,
    output logic                   o_irq_high
);

    localparam int LAT_MAX = TCY_NS / CLK_NS;

    mttu_phase_e phase_q;
    mttu_phase_e phase_d;
    mttu_ctrl_s  ctrl_q;
    mttu_ctrl_s  ctrl_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [7:0]  hbuf_q;
    logic [7:0]  per_lo_q;
    logic [7:0]  per_hi_q;
    logic [7:0]  capture_one_input_q;
    logic [7:0]  flt_q;
    logic        flag_q;
    logic        en_q;
    logic        pri_q;
    logic [2:0]  presc_q;
    logic [2:0]  presc_d;
    logic        pend_q;
    logic        trig_q;
    logic        irq_q;
    logic        ext_pend_q;
    logic        filt_prev_q;
    logic [31:0] rdata_q;
    logic [7:0]  rd8;

    // Bus phase decode
    wire acc      = i_psel & i_penable;
    wire wr       = acc & i_pwrite;
    wire setup_rd = i_psel & ~i_penable & ~i_pwrite;

    // Address decode
    wire hit_ctrl = (i_paddr == OFF_CTRL);
    wire hit_clo  = (i_paddr == OFF_CNT_LO);
    wire hit_chi  = (i_paddr == OFF_CNT_HI);
    wire hit_plo  = (i_paddr == OFF_PER_LO);
    wire hit_phi  = (i_paddr == OFF_PER_HI);
    wire hit_cap  = (i_paddr == OFF_CAPTURE_ONE_INPUT);
    wire hit_flt  = (i_paddr == OFF_FLT);
    wire hit_flg  = (i_paddr == OFF_IRQ_FLG);
    wire hit_en   = (i_paddr == OFF_IRQ_EN);
    wire hit_pri  = (i_paddr == OFF_IRQ_PRI);
    wire hit_any  = hit_ctrl | hit_clo | hit_chi | hit_plo | hit_phi
                  | hit_cap | hit_flt | hit_flg | hit_en | hit_pri;

    // Write strobes per register
    wire wr_ctrl   = wr & hit_ctrl;
    wire wr_cnt_lo = wr & hit_clo;
    wire wr_cnt_hi = wr & hit_chi;
    wire wr_flag   = wr & hit_flg;
    wire [15:0] wr_val = {hbuf_q, i_pwdata[7:0]};

    // Zero wait states; unmapped addresses answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = acc & ~hit_any;
    assign o_prdata  = rdata_q;
    assign o_trigger = trig_q;
    assign o_irq     = irq_q;
    assign o_irq_high = pri_q;

    // Phase sequencer: a 40 MHz clock gives four phases per instruction cycle
    always_comb begin
        phase_d = PH_Q1;
        case (phase_q)
            PH_Q1:   phase_d = PH_Q2;
            PH_Q2:   phase_d = PH_Q3;
            PH_Q3:   phase_d = PH_Q4;
            default: phase_d = PH_Q1;
        endcase
    end

    wire q1 = (phase_q == PH_Q1);
    wire q3 = (phase_q == PH_Q3);
    wire q4 = (phase_q == PH_Q4);
    wire sample_en = (phase_q == PH_Q2) | q4;

    // External input path, sampled on second and fourth phases
    logic filt;
    mttu_filter #(
        .DEPTH (FILT_STABLE)
    ) u_filter (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_sample (sample_en),
        .i_en     (flt_q[FILT_EN_BIT]),
        .i_in     (i_ext_count),
        .o_out    (filt)
    );
    wire ext_rise = filt & ~filt_prev_q;

    // Trigger reset acceptance, armed only by the capture trigger modes
    wire cap_trig = (capture_one_input_q[3:0] == CAPM_TRIG_A)
                  | (capture_one_input_q[3:0] == CAPM_TRIG_B);
    wire trig_ok  = i_capture_one_input_event & cap_trig & ~ctrl_q.trigger_reset_disable;

    // Sleep gating; synchronous modes freeze because their clock is gone
    wire sleep_run = ctrl_q.sleep_run_enable & ctrl_q.external_clock_select
                   & ctrl_q.no_sync_select;
    wire run_ok = ctrl_q.timer_run_bit & (~i_sleep | sleep_run);

    // Timer clock: instruction cycle or pending external edge, both on Q1
    wire src_tick = ctrl_q.external_clock_select ? ext_pend_q : 1'b1;
    wire raw_tick = run_ok & q1 & src_tick;
    wire ptick    = raw_tick & (presc_q == mttu_presc_last(ctrl_q.prescale_select));

    // Period match; a bus write or trigger reset in the same cycle pre-empts it
    wire at_period  = (cnt_q == {per_hi_q, per_lo_q});
    wire match_tick = ptick & at_period & ~wr_cnt_lo & ~trig_ok;
    wire shot_end   = match_tick & ctrl_q.single_shot_select;
    wire edge_start = trig_ok & ctrl_q.single_shot_select & ~ctrl_q.timer_run_bit;

    // Prescaler next value
    always_comb begin
        presc_d = presc_q;
        if (!ctrl_q.timer_run_bit || wr_cnt_lo || trig_ok || i_bor) begin
            presc_d = 3'h0;
        end else if (ptick) begin
            presc_d = 3'h0;
        end else if (raw_tick) begin
            presc_d = presc_q + 3'h1;
        end
    end

    // Count next value: bus write, then trigger reset, then counting
    always_comb begin
        cnt_d = cnt_q;
        if (wr_cnt_lo) begin
            cnt_d = wr_val;
        end else if (trig_ok) begin
            cnt_d = RST_WORD;
        end else if (ptick) begin
            cnt_d = at_period ? RST_WORD : cnt_q + 16'h0001;
        end
    end

    // Control next value; a control write leaves the count alone
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = mttu_ctrl_s'(i_pwdata[7:0]);
        end else if (shot_end) begin
            ctrl_d.timer_run_bit = 1'b0;
        end else if (edge_start) begin
            ctrl_d.timer_run_bit = 1'b1;
        end
    end

    // Read data mux
    always_comb begin
        rd8 = RST_BYTE;
        if (hit_ctrl) begin
            rd8 = ctrl_q;
        end else if (hit_clo) begin
            rd8 = cnt_q[7:0];
        end else if (hit_chi) begin
            rd8 = hbuf_q;
        end else if (hit_plo) begin
            rd8 = per_lo_q;
        end else if (hit_phi) begin
            rd8 = per_hi_q;
        end else if (hit_cap) begin
            rd8 = capture_one_input_q;
        end else if (hit_flt) begin
            rd8 = flt_q;
        end else if (hit_flg) begin
            rd8 = {7'h00, flag_q};
        end else if (hit_en) begin
            rd8 = {7'h00, en_q};
        end else if (hit_pri) begin
            rd8 = {7'h00, pri_q};
        end
    end

    // Phase, control, count and prescaler state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            phase_q <= PH_Q1;
            ctrl_q  <= mttu_ctrl_s'(RST_BYTE);
            cnt_q   <= RST_WORD;
            presc_q <= 3'h0;
        end else begin
            phase_q <= phase_d;
            ctrl_q  <= ctrl_d;
            cnt_q   <= cnt_d;
            presc_q <= presc_d;
        end
    end

    // High buffer: written directly, or loaded from the count on a low byte read
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            hbuf_q <= RST_BYTE;
        end else if (wr_cnt_hi) begin
            hbuf_q <= i_pwdata[7:0];
        end else if (setup_rd && hit_clo) begin
            hbuf_q <= cnt_q[15:8];
        end
    end

    // Plain configuration registers; brown-out kills the filter enable
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            per_lo_q <= RST_BYTE;
            per_hi_q <= RST_BYTE;
            capture_one_input_q   <= RST_BYTE;
            flt_q    <= RST_BYTE;
            en_q     <= 1'b0;
            pri_q    <= 1'b0;
        end else begin
            if (wr && hit_plo) per_lo_q <= i_pwdata[7:0];
            if (wr && hit_phi) per_hi_q <= i_pwdata[7:0];
            if (wr && hit_cap) capture_one_input_q <= i_pwdata[7:0] & CAPTURE_ONE_INPUT_MASK;
            if (i_bor) begin
                flt_q[FILT_EN_BIT] <= 1'b0;
            end else if (wr && hit_flt) begin
                flt_q <= i_pwdata[7:0] & FLT_MASK;
            end
            if (wr && hit_en) en_q <= i_pwdata[IRQ_BIT];
            if (wr && hit_pri) pri_q <= i_pwdata[IRQ_BIT];
        end
    end

    // Match pipeline: trigger high through Q4, flag set at Q4 edge; set beats clear
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pend_q <= 1'b0;
            trig_q <= 1'b0;
            flag_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            pend_q <= match_tick | (pend_q & ~q4);
            trig_q <= pend_q & q3;
            flag_q <= (pend_q & q4)
                    | (wr_flag ? i_pwdata[IRQ_BIT] : flag_q);
            irq_q  <= flag_q & en_q;
        end
    end

    // Edge detect and read data capture at setup
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ext_pend_q  <= 1'b0;
            filt_prev_q <= 1'b0;
            rdata_q     <= 32'h0000_0000;
        end else begin
            ext_pend_q  <= ext_rise | (ext_pend_q & ~q1);
            filt_prev_q <= filt;
            if (setup_rd) rdata_q <= {24'h00_0000, rd8};
        end
    end

    // Checks on the timing of match, trigger and count priority
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_flag_set;
        ##[1:LAT_MAX] flag_q;
    endsequence

    sequence s_trig_out;
        ##3 o_trigger ##1 !o_trigger;
    endsequence

    flag_latency_a: assert property (match_tick |-> s_flag_set)
        else $error("flag not set within one instruction cycle");
    trig_phase_a: assert property (match_tick |-> s_trig_out)
        else $error("trigger missing or misplaced after match");
    trig_pulse_a: assert property (o_trigger |=> !o_trigger)
        else $error("trigger longer than one cycle");
    presc_clear_a: assert property (wr_cnt_lo |=> presc_q == 3'h0)
        else $error("prescaler not cleared by count write");
    presc_off_a: assert property (!ctrl_q.timer_run_bit || i_bor |=> presc_q == 3'h0)
        else $error("prescaler not cleared while stopped or on brown-out");
    ctrl_keep_a: assert property (wr_ctrl && !trig_ok && !ptick |=> $stable(cnt_q))
        else $error("control write disturbed the count");
    bus_wins_a: assert property (wr_cnt_lo && trig_ok |=> cnt_q == $past(wr_val))
        else $error("trigger reset beat the bus write");
    shot_stop_a: assert property (shot_end && !wr_ctrl |=> !ctrl_q.timer_run_bit)
        else $error("single-shot match left the timer running");
    rst_dis_a: assert property (i_capture_one_input_event && ctrl_q.trigger_reset_disable
        && !wr_cnt_lo && !ptick |=> $stable(cnt_q))
        else $error("disabled trigger reset changed the count");
    edge_start_a: assert property (edge_start && !wr_ctrl |=> ctrl_q.timer_run_bit)
        else $error("capture edge did not start the timer");
    // Judged on the count itself, so a broken sleep gate cannot hide behind the tick net
    sleep_stop_a: assert property (i_sleep && !ctrl_q.sleep_run_enable && !wr_cnt_lo
        && !trig_ok |=> $stable(cnt_q))
        else $error("timer counted in sleep without sleep-run");
    flt_bor_a: assert property (i_bor |=> !flt_q[FILT_EN_BIT])
        else $error("brown-out left the filter enabled");

endmodule

/* tb/mttu_partner.sv */
`timescale 1ns/1ps
module mttu_partner (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    // Bench request and timer trigger
    input  wire logic       i_fire,
    input  wire logic       i_trigger,
    // Capture edge and conversions started
    output logic            o_capture_one_input_event,
    output logic [7:0]      o_conv_cnt
);
    // Capture one edge, one cycle per request, registered so it never glitches
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_capture_one_input_event <= 1'b0;
        end else begin
            o_capture_one_input_event <= i_fire;
        end
    end
    // Converter starts once for every trigger cycle seen
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_conv_cnt <= 8'h00;
        end else if (i_trigger) begin
            o_conv_cnt <= o_conv_cnt + 8'h01;
        end
    end
endmodule

/* tb/motion_timer_trigger_unit_bench.sv */
`timescale 1ns/1ps
module motion_timer_trigger_unit_bench
    import mttu_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        sleep = 1'b0, bor = 1'b0, ext = 1'b0, fire = 1'b0;
    logic        capture_one_input, er, pready, pslverr, trig, irq, irq_hi;
    logic [7:0]  paddr = 8'h00;
    logic [7:0]  cvc;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic [15:0] cnt;
    int          n_fail = 0, total_checks = 0, cyc = 0, n, tc;

    // Design and its far side
    mttu_top uut (
        .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_sleep(sleep), .i_bor(bor), .i_ext_count(ext),
        .i_capture_one_input_event(capture_one_input), .o_trigger(trig), .o_irq(irq), .o_irq_high(irq_hi)
    );
    mttu_partner far (
        .i_clk(clk), .i_rst_n(rst_n), .i_fire(fire), .i_trigger(trig),
        .o_capture_one_input_event(capture_one_input), .o_conv_cnt(cvc)
    );

    // Clock, 25 ns period
    always #12.5 clk = ~clk;

    task automatic close_out;
        if (n_fail == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard, far above the 1,300 or so cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // APB cycle; f raises a capture edge that lands in the access cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic f);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        fire <= f;
        @(posedge clk);
        pen <= 1'b1;
        fire <= 1'b0;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, 1'b0);
    endtask

    // Low byte first so the high byte is latched coherently
    task automatic rdc;
        rd(OFF_CNT_LO);
        cnt[7:0] = q[7:0];
        rd(OFF_CNT_HI);
        cnt[15:8] = q[7:0];
    endtask

    task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
        wr(hi, 32'(v[15:8]));
        wr(lo, 32'(v[7:0]));
    endtask

    // Leaves two edges so the effect is in place before the next setup
    task automatic pulse;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // External pulses, h cycles high then 14 low
    task automatic edges(input int k, input int h);
        repeat (k) begin
            @(posedge clk);
            ext <= 1'b1;
            repeat (h) @(posedge clk);
            ext <= 1'b0;
            repeat (14) @(posedge clk);
        end
    endtask

    task automatic waittrig;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (trig !== 1'b1 && n < 3000);
    endtask

    task automatic t_regs;
        for (int a = 0; a <= 'h24; a += 4) begin
            rd(8'(a));
            chk(q, 32'h0);
            chk(32'(er), 32'h0);
        end
        rd(8'h30);
        chk(q, 32'h0);
        chk(32'(er), 32'h1);
        wr(OFF_CAPTURE_ONE_INPUT, 32'hff);
        rd(OFF_CAPTURE_ONE_INPUT);
        chk(q, 32'(CAPTURE_ONE_INPUT_MASK));
        wr(OFF_FLT, 32'hff);
        rd(OFF_FLT);
        chk(q, 32'(FLT_MASK));
        wr(OFF_FLT, 32'h0);
    endtask

    // Period 2 gives three ticks per match, each four cycles times the prescale ratio
    task automatic t_presc;
        for (int ps = 0; ps < 4; ps++) begin
            wr(OFF_CTRL, 32'h0);
            wr16(OFF_PER_LO, OFF_PER_HI, 16'h0002);
            wr16(OFF_CNT_LO, OFF_CNT_HI, 16'h0000);
            wr(OFF_CTRL, 32'((ps << 3) | 1));
            waittrig();
            @(negedge clk);
            chk(32'(trig), 32'h0);
            waittrig();
            chk(n + 1, 12 << ps);
        end
    endtask

    task automatic t_irq;
        wr(OFF_CTRL, 32'h0);
        wr(OFF_IRQ_FLG, 32'h0);
        wr(OFF_IRQ_EN, 32'h1);
        wr16(OFF_CNT_LO, OFF_CNT_HI, 16'h0000);
        wr(OFF_CTRL, 32'h19);
        waittrig();
        @(negedge clk);
        chk(32'(irq), 32'h0);
        @(negedge clk);
        chk(32'(irq), 32'h1);
        rd(OFF_IRQ_FLG);
        chk(q, 32'h1);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_IRQ_FLG, 32'h0);
        wr(OFF_IRQ_PRI, 32'h1);
        repeat (3) @(negedge clk);
        chk(32'(irq), 32'h0);
        chk(32'(irq_hi), 32'h1);
    endtask

    task automatic t_load;
        wr16(OFF_CNT_LO, OFF_CNT_HI, 16'h1234);
        wr(OFF_CTRL, 32'h18);
        rdc();
        chk(32'(cnt), 32'h1234);
        wr(OFF_CNT_HI, 32'h55);
        rdc();
        chk(32'(cnt), 32'h1234);
    endtask

    // Only trigger modes with the disable bit clear may zero the count
    task automatic t_treset;
        logic [3:0] md [4] = '{CAPM_TRIG_A, CAPM_TRIG_B, CAPM_TRIG_A, 4'hb};
        logic       ds [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CTRL, 32'(ds[i]) << 6);
            wr(OFF_CAPTURE_ONE_INPUT, 32'(md[i]));
            wr16(OFF_CNT_LO, OFF_CNT_HI, 16'h0010);
            pulse();
            rdc();
            chk(32'(cnt), (md[i][3:1] == 3'h7 && !ds[i]) ? 32'h0 : 32'h10);
        end
    endtask

    task automatic t_race;
        wr(OFF_CAPTURE_ONE_INPUT, 32'(CAPM_TRIG_A));
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CNT_HI, 32'h0);
        apb(1'b1, OFF_CNT_LO, 32'h21, 1'b1);
        rdc();
        chk(32'(cnt), 32'h21);
    endtask

    task automatic t_shot;
        wr(OFF_CTRL, 32'h20);
        wr16(OFF_PER_LO, OFF_PER_HI, 16'h0002);
        wr16(OFF_CNT_LO, OFF_CNT_HI, 16'h0000);
        tc = cvc;
        pulse();
        rd(OFF_CTRL);
        chk(q, 32'h21);
        waittrig();
        repeat (2) @(negedge clk);
        rd(OFF_CTRL);
        chk(q, 32'h20);
        repeat (40) @(negedge clk);
        rdc();
        chk(32'(cnt), 32'h0);
        chk(32'(cvc), 32'(tc + 1));
    endtask

    // Trigger is not judged here: the no-sync mode makes it unreliable
    task automatic t_sleep;
        wr16(OFF_PER_LO, OFF_PER_HI, 16'h00ff);
        wr16(OFF_CNT_LO, OFF_CNT_HI, 16'h0000);
        wr(OFF_CTRL, 32'h81);
        sleep <= 1'b1;
        repeat (40) @(posedge clk);
        rdc();
        chk(32'(cnt), 32'h0);
        wr(OFF_CTRL, 32'h07);
        edges(2, 8);
        rdc();
        chk(32'(cnt), 32'h0);
        wr(OFF_CTRL, 32'h87);
        wr16(OFF_PER_LO, OFF_PER_HI, 16'h0004);
        wr(OFF_IRQ_FLG, 32'h0);
        edges(4, 8);
        rdc();
        chk(32'(cnt), 32'h4);
        edges(1, 8);
        rdc();
        chk(32'(cnt), 32'h0);
        chk(32'(irq), 32'h1);
        sleep <= 1'b0;
        wr(OFF_CTRL, 32'h0);
        wr(OFF_IRQ_FLG, 32'h0);
    endtask

    // Two-cycle glitches reach one sample only, so the filter must drop them
    task automatic t_filter;
        wr16(OFF_PER_LO, OFF_PER_HI, 16'h00ff);
        wr(OFF_CTRL, 32'h03);
        for (int en = 1; en >= 0; en--) begin
            wr(OFF_FLT, 32'(en << FILT_EN_BIT));
            wr16(OFF_CNT_LO, OFF_CNT_HI, 16'h0000);
            edges(3, 2);
            rdc();
            chk(32'(cnt), en ? 32'h0 : 32'h3);
        end
        wr(OFF_FLT, 32'h40);
        wr16(OFF_CNT_LO, OFF_CNT_HI, 16'h0000);
        edges(2, 16);
        rdc();
        chk(32'(cnt), 32'h2);
        wr(OFF_CTRL, 32'h0);
        @(posedge clk);
        bor <= 1'b1;
        @(posedge clk);
        bor <= 1'b0;
        @(posedge clk);
        rd(OFF_FLT);
        chk(q, 32'h0);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_presc();
        t_irq();
        t_load();
        t_treset();
        t_race();
        t_shot();
        t_sleep();
        t_filter();
        close_out();
    end
endmodule
